// [hw/csbu_pkg.sv]
`default_nettype none
package csbu_pkg;

  // Register byte addresses
  localparam logic [7:0] ADDR_OPER = 8'h00;
  localparam logic [7:0] ADDR_OPND = 8'h04;
  localparam logic [7:0] ADDR_PC = 8'h08;
  localparam logic [7:0] ADDR_FLAGS = 8'h0C;
  localparam logic [7:0] ADDR_STAT = 8'h10;

  // Field positions
  localparam int OPER_OP_LSB = 0;
  localparam int OPER_SEL_LSB = 4;
  localparam int OPER_TWO_BIT = 7;
  localparam int OPND_RD_LSB = 0;
  localparam int OPND_RR_LSB = 8;
  localparam int OPND_IO_LSB = 16;
  localparam int OPND_K_LSB = 24;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_TAKEN_BIT = 1;

  // Flag register bit positions
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_H = 5;

  // Values after reset
  localparam logic [15:0] PC_RST = 16'h0000;
  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam logic [7:0] OPER_RST = 8'h00;
  localparam logic [31:0] OPND_RST = 32'h0000_0000;

  // Execution cycle counts
  localparam logic [1:0] CYC_ONE = 2'h1;
  localparam logic [1:0] CYC_TWO = 2'h2;
  localparam logic [1:0] CYC_THREE = 2'h3;

  // Skip distances in words
  localparam logic [15:0] SKIP_ONE_WORD = 16'h0002;
  localparam logic [15:0] SKIP_TWO_WORD = 16'h0003;
  localparam logic [15:0] PC_STEP = 16'h0001;

  typedef enum logic [3:0] {
    OP_COMPARE,
    OP_COMPARE_WITH_CARRY_IN,
    OP_COMPARE_IMMEDIATE,
    OP_SKIP_REG_BIT_CLEAR,
    OP_SKIP_REG_BIT_SET,
    OP_SKIP_IO_BIT_CLEAR,
    OP_SKIP_IO_BIT_SET,
    OP_BRANCH_FLAG_SET,
    OP_BRANCH_FLAG_CLEAR,
    OP_BRANCH_ZERO_SET,
    OP_BRANCH_ZERO_CLEAR,
    OP_BRANCH_CARRY_SET,
    OP_BRANCH_CARRY_CLEAR,
    OP_BRANCH_UNSIGNED_GE,
    OP_BRANCH_UNSIGNED_LT,
    OP_BRANCH_NEGATIVE
  } csbu_op_e;

  typedef enum logic {
    ST_IDLE,
    ST_EXEC
  } csbu_state_e;

endpackage
`default_nettype wire

// [hw/csbu_exec_if.sv]
`timescale 1ns/10ps
`default_nettype none
interface csbu_exec_if;
  csbu_pkg::csbu_op_e op;
  logic [2:0] sel;
  logic two_word;
  logic [7:0] rd;
  logic [7:0] rr;
  logic [7:0] io_val;
  logic [7:0] flags_in;
  logic [7:0] flags_out;
  logic taken;
  logic [1:0] cycles;
  modport ctrl (output op, sel, two_word, rd, rr, io_val, flags_in,
                input flags_out, taken, cycles);
  modport eval (input op, sel, two_word, rd, rr, io_val, flags_in,
                output flags_out, taken, cycles);
endinterface
`default_nettype wire

// [hw/csbu_eval.sv]
`timescale 1ns/10ps
`default_nettype none
module csbu_eval
  import csbu_pkg::*;
(
  // Operation and operands in, decision out
  csbu_exec_if.eval ex
);

  logic is_cmp;
  logic cin;
  logic zero;
  logic half;
  logic carry;
  logic ovf;
  logic [7:0] diff;
  logic [7:0] upd;
  logic taken;

  ////////////////////////////////////////////////////////////////////////
  // Compare: difference discarded, only flags kept
  assign is_cmp = (ex.op == OP_COMPARE) ||
                  (ex.op == OP_COMPARE_WITH_CARRY_IN) ||
                  (ex.op == OP_COMPARE_IMMEDIATE);
  assign cin = (ex.op == OP_COMPARE_WITH_CARRY_IN) & ex.flags_in[FLAG_C];
  assign diff = ex.rd - ex.rr - {7'h00, cin};
  assign half = (~ex.rd[3] & ex.rr[3]) | (ex.rr[3] & diff[3]) |
                (diff[3] & ~ex.rd[3]);
  assign carry = (~ex.rd[7] & ex.rr[7]) | (ex.rr[7] & diff[7]) |
                 (diff[7] & ~ex.rd[7]);
  assign ovf = (ex.rd[7] & ~ex.rr[7] & ~diff[7]) |
               (~ex.rd[7] & ex.rr[7] & diff[7]);
  // With carry in, zero only stays set across a chained compare
  assign zero = (diff == 8'h00) &
                ((ex.op != OP_COMPARE_WITH_CARRY_IN) | ex.flags_in[FLAG_Z]);

  always_comb begin
    upd = ex.flags_in;
    upd[FLAG_H] = half;
    upd[FLAG_V] = ovf;
    upd[FLAG_N] = diff[7];
    upd[FLAG_Z] = zero;
    upd[FLAG_C] = carry;
  end

  // Skips and branches leave every flag alone
  assign ex.flags_out = is_cmp ? upd : ex.flags_in;

  ////////////////////////////////////////////////////////////////////////
  // Skip and branch conditions
  always_comb begin
    case (ex.op)
      OP_SKIP_REG_BIT_CLEAR: taken = ~ex.rr[ex.sel];
      OP_SKIP_REG_BIT_SET: taken = ex.rr[ex.sel];
      OP_SKIP_IO_BIT_CLEAR: taken = ~ex.io_val[ex.sel];
      OP_SKIP_IO_BIT_SET: taken = ex.io_val[ex.sel];
      OP_BRANCH_FLAG_SET: taken = ex.flags_in[ex.sel];
      OP_BRANCH_FLAG_CLEAR: taken = ~ex.flags_in[ex.sel];
      OP_BRANCH_ZERO_SET: taken = ex.flags_in[FLAG_Z];
      OP_BRANCH_ZERO_CLEAR: taken = ~ex.flags_in[FLAG_Z];
      OP_BRANCH_CARRY_SET: taken = ex.flags_in[FLAG_C];
      OP_BRANCH_CARRY_CLEAR: taken = ~ex.flags_in[FLAG_C];
      OP_BRANCH_UNSIGNED_GE: taken = ~ex.flags_in[FLAG_C];
      OP_BRANCH_UNSIGNED_LT: taken = ex.flags_in[FLAG_C];
      OP_BRANCH_NEGATIVE: taken = ex.flags_in[FLAG_N];
      default: taken = 1'b0;
    endcase
  end

  assign ex.taken = taken;

  // Cycle counts: skips 1/2/3, branches 1/2, compares 1
  assign ex.cycles = ~taken ? CYC_ONE :
                     (ex.op >= OP_BRANCH_FLAG_SET) ? CYC_TWO :
                     ex.two_word ? CYC_THREE : CYC_TWO;

endmodule
`default_nettype wire

// [hw/csbu_top.sv]
`timescale 1ns/10ps
`default_nettype none
module csbu_top
  import csbu_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);

  csbu_exec_if ex ();

  csbu_state_e state;
  csbu_state_e next_state;
  logic [7:0] oper;
  logic [31:0] opnd;
  logic [15:0] pc;
  logic [7:0] flag_register;
  logic [1:0] elapsed;
  logic [1:0] next_elapsed;
  logic [1:0] last_cyc;
  logic taken_last;
  logic [15:0] next_pc;
  logic [7:0] next_flags;
  logic [31:0] rd_mux;
  logic setup;
  logic busy;
  logic hit;
  logic refuse;
  logic wr_en;
  logic start;
  logic commit;
  logic is_branch;
  logic [15:0] k_ext;

  ////////////////////////////////////////////////////////////////////////
  // Operation and operands to the evaluator
  assign ex.op = csbu_op_e'(oper[OPER_OP_LSB +: 4]);
  assign ex.sel = oper[OPER_SEL_LSB +: 3];
  assign ex.two_word = oper[OPER_TWO_BIT];
  assign ex.rd = opnd[OPND_RD_LSB +: 8];
  assign ex.rr = opnd[OPND_RR_LSB +: 8];
  assign ex.io_val = opnd[OPND_IO_LSB +: 8];
  assign ex.flags_in = flag_register;

  csbu_eval u_eval (
    .ex(ex.eval)
  );

  ////////////////////////////////////////////////////////////////////////
  // APB decode
  assign setup = psel & ~penable;
  assign busy = (state == ST_EXEC);
  assign hit = (paddr == ADDR_OPER) || (paddr == ADDR_OPND) ||
               (paddr == ADDR_PC) || (paddr == ADDR_FLAGS) ||
               (paddr == ADDR_STAT);
  assign refuse = ~hit | (pwrite & busy);
  assign wr_en = psel & penable & pready & pwrite & ~pslverr;
  assign start = wr_en & (paddr == ADDR_OPER);

  assign rd_mux = (paddr == ADDR_OPER) ? {24'h00_0000, oper} :
                  (paddr == ADDR_OPND) ? opnd :
                  (paddr == ADDR_PC) ? {16'h0000, pc} :
                  (paddr == ADDR_FLAGS) ? {24'h00_0000, flag_register} :
                  (paddr == ADDR_STAT) ?
                    {30'h0000_0000, taken_last, busy} : 32'h0000_0000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= setup;
      pslverr <= setup & refuse;
      prdata <= (setup & ~pwrite & hit) ? rd_mux : 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Execution sequencing
  // Count is taken from the locked operation, never at the start edge
  assign last_cyc = ex.cycles - CYC_ONE;
  assign commit = busy & (elapsed == last_cyc);
  assign next_elapsed = (busy & ~commit) ? elapsed + 2'h1 : 2'h0;

  always_comb begin
    case (state)
      ST_IDLE: next_state = start ? ST_EXEC : ST_IDLE;
      ST_EXEC: next_state = commit ? ST_IDLE : ST_EXEC;
      default: next_state = ST_IDLE;
    endcase
  end

  assign is_branch = (ex.op >= OP_BRANCH_FLAG_SET);
  assign k_ext = {{9{opnd[OPND_K_LSB + 6]}}, opnd[OPND_K_LSB +: 7]};

  // Taken branch adds k+1, taken skip steps over one or two words
  assign next_pc = ~ex.taken ? pc + PC_STEP :
                   is_branch ? pc + k_ext + PC_STEP :
                   ex.two_word ? pc + SKIP_TWO_WORD :
                   pc + SKIP_ONE_WORD;
  assign next_flags = ex.flags_out;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_IDLE;
      elapsed <= 2'h0;
    end else begin
      state <= next_state;
      elapsed <= next_elapsed;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Software visible registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      oper <= OPER_RST;
      opnd <= OPND_RST;
    end else begin
      if (wr_en && paddr == ADDR_OPER) oper <= pwdata[7:0];
      if (wr_en && paddr == ADDR_OPND) opnd <= pwdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc <= PC_RST;
      flag_register <= FLAGS_RST;
      taken_last <= 1'b0;
    end else if (commit) begin
      pc <= next_pc;
      flag_register <= next_flags;
      taken_last <= ex.taken;
    end else begin
      if (wr_en && paddr == ADDR_PC) pc <= pwdata[15:0];
      if (wr_en && paddr == ADDR_FLAGS) flag_register <= pwdata[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  logic st_cmp;
  logic st_rskip;
  logic st_ioskip;
  assign st_cmp = start && (pwdata[3:0] <= 4'(OP_COMPARE_IMMEDIATE));
  assign st_rskip = start &&
                    (pwdata[3:0] == 4'(OP_SKIP_REG_BIT_CLEAR));
  assign st_ioskip = busy && (elapsed == 2'h0) && ex.taken &&
                     ex.two_word && (ex.op == OP_SKIP_IO_BIT_SET);

  chk_cmp_one_cycle: assert property (
    @(posedge pclk) disable iff (!presetn)
    st_cmp |=> commit ##1 !busy)
    else $error("compare did not finish in one cycle");

  chk_cmp_equal_zero: assert property (
    @(posedge pclk) disable iff (!presetn)
    commit && ex.op == OP_COMPARE && ex.rd == ex.rr
    |=> flag_register[FLAG_Z] && !flag_register[FLAG_C])
    else $error("equal compare did not set zero");

  chk_rskip_pc_step: assert property (
    @(posedge pclk) disable iff (!presetn)
    st_rskip ##1 (ex.taken && !ex.two_word)
    |-> ##2 pc == 16'($past(pc, 3) + SKIP_ONE_WORD))
    else $error("register skip moved pc wrongly");

  chk_ioskip_three: assert property (
    @(posedge pclk) disable iff (!presetn)
    st_ioskip |-> !commit ##1 !commit ##1 commit ##1
      (pc == 16'($past(pc, 3) + SKIP_TWO_WORD) &&
       flag_register == $past(flag_register, 3)))
    else $error("two word io skip wrong");

  chk_flag_set_taken: assert property (
    @(posedge pclk) disable iff (!presetn)
    busy && ex.op == OP_BRANCH_FLAG_SET && ex.taken && elapsed == 2'h0
    |-> !commit ##1 commit ##1 pc == 16'($past(pc, 2) + k_ext + PC_STEP))
    else $error("flag set branch target wrong");

  chk_flag_clr_hold: assert property (
    @(posedge pclk) disable iff (!presetn)
    commit && ex.op == OP_BRANCH_FLAG_CLEAR
    |=> flag_register == $past(flag_register))
    else $error("flag clear branch changed flags");

  chk_carry_clear_br: assert property (
    @(posedge pclk) disable iff (!presetn)
    commit && ex.op == OP_BRANCH_CARRY_CLEAR && flag_register[FLAG_C]
    |=> pc == 16'($past(pc) + PC_STEP))
    else $error("carry clear branch taken with carry");

  chk_unsigned_ge: assert property (
    @(posedge pclk) disable iff (!presetn)
    busy && ex.op == OP_BRANCH_UNSIGNED_GE && !flag_register[FLAG_C]
    && elapsed == 2'h0 |-> !commit ##1 commit)
    else $error("unsigned ge branch not two cycles");

  chk_not_taken_one: assert property (
    @(posedge pclk) disable iff (!presetn)
    start |=> (busy && is_branch && !ex.taken) |-> commit)
    else $error("untaken branch took more than one cycle");

  cov_compare: cover property (@(posedge pclk) disable iff (!presetn)
    commit && ex.op == OP_COMPARE_WITH_CARRY_IN);
  cov_io_skip: cover property (@(posedge pclk) disable iff (!presetn)
    commit && ex.op == OP_SKIP_IO_BIT_CLEAR && ex.taken);
  cov_branch: cover property (@(posedge pclk) disable iff (!presetn)
    commit && ex.op == OP_BRANCH_NEGATIVE && ex.taken);

endmodule
`default_nettype wire

// [dv/tb.sv]
`timescale 1ns/10ps
`default_nettype none
module tb;
  import csbu_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  int bad_count = 0;
  int checks_done = 0;
  int cyc = 0;
  logic [31:0] rv;
  logic er;

  csbu_top uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));

  always #2 pclk = ~pclk;

  ////////////////////////////////////////
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      stop_test();
    end
  end

  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One APB transfer; psel stays up so another may follow at once
  task automatic xfer(logic wr, logic [7:0] a, logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rv = prdata;
    er = pslverr;
    penable <= 1'b0;
  endtask

  task automatic acc(logic wr, logic [7:0] a, logic [31:0] d);
    xfer(wr, a, d);
    psel <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wait_idle();
    do begin
      acc(1'b0, ADDR_STAT, 32'h0);
    end while (rv[STAT_BUSY_BIT] !== 1'b0);
  endtask

  task automatic run(logic [3:0] op, logic [2:0] s, logic tw,
                     logic [31:0] od, logic [15:0] pc, logic [7:0] fl);
    acc(1'b1, ADDR_PC, {16'h0000, pc});
    acc(1'b1, ADDR_FLAGS, {24'h000000, fl});
    acc(1'b1, ADDR_OPND, od);
    acc(1'b1, ADDR_OPER, {24'h000000, tw, s, op});
    wait_idle();
  endtask

  task automatic expect_pc_fl(logic [15:0] pc, logic [7:0] fl);
    acc(1'b0, ADDR_PC, 32'h0);
    check("pc", rv, {16'h0000, pc});
    acc(1'b0, ADDR_FLAGS, 32'h0);
    check("flags", rv, {24'h000000, fl});
  endtask

  function automatic logic [7:0] cmpf(logic [7:0] d, logic [7:0] r,
                                      logic c, logic [7:0] f, logic wc);
    logic [8:0] t;
    logic [4:0] h;
    logic [7:0] o;
    t = {1'b0, d} - {1'b0, r} - c;
    h = {1'b0, d[3:0]} - {1'b0, r[3:0]} - c;
    o = f & 8'hD0;
    o[FLAG_C] = t[8];
    o[FLAG_H] = h[4];
    o[FLAG_N] = t[7];
    o[FLAG_V] = (d[7] & ~r[7] & ~t[7]) | (~d[7] & r[7] & t[7]);
    o[FLAG_Z] = (t[7:0] == 8'h00) & (~wc | f[FLAG_Z]);
    return o;
  endfunction

  function automatic logic cond(logic [3:0] op, logic [2:0] s,
                                logic [7:0] f);
    case (op)
      4'h7: return f[s];
      4'h8: return ~f[s];
      4'h9: return f[FLAG_Z];
      4'hA: return ~f[FLAG_Z];
      4'hB, 4'hE: return f[FLAG_C];
      4'hC, 4'hD: return ~f[FLAG_C];
      default: return f[FLAG_N];
    endcase
  endfunction

  ////////////////////////////////////////
  task automatic t_reset();
    acc(1'b0, ADDR_PC, 32'h0);
    check("pc_rst", rv, {16'h0000, PC_RST});
    acc(1'b0, ADDR_FLAGS, 32'h0);
    check("fl_rst", rv, {24'h000000, FLAGS_RST});
    acc(1'b0, ADDR_STAT, 32'h0);
    check("stat_rst", rv, 32'h0000_0000);
    acc(1'b0, 8'h14, 32'h0);
    check("unmapped", {31'h0, er}, 32'h0000_0001);
    $display("test reset done");
  endtask

  task automatic t_compare();
    logic [7:0] d [4] = '{8'h10, 8'h20, 8'h80, 8'h01};
    logic [7:0] r [4] = '{8'h20, 8'h20, 8'h01, 8'h80};
    logic [7:0] f;
    for (int op = 0; op < 3; op++) begin
      for (int i = 0; i < 4; i++) begin
        f = i[0] ? 8'hD3 : 8'h02;
        run(op[3:0], 3'h0, 1'b0, {16'h0000, r[i], d[i]}, 16'h0040, f);
        expect_pc_fl(16'h0041, cmpf(d[i], r[i],
                     (op == 1) & f[FLAG_C], f, op == 1));
      end
    end
    $display("test compare done");
  endtask

  task automatic t_skip();
    logic [7:0] b;
    logic tk;
    logic [15:0] e;
    for (int op = 3; op < 7; op++) begin
      for (int i = 0; i < 4; i++) begin
        b = i[0] ? 8'h20 : 8'hDF;
        tk = op[0] ? ~i[0] : i[0];
        e = tk ? (i[1] ? 16'h0203 : 16'h0202) : 16'h0201;
        run(op[3:0], 3'h5, i[1], (op < 5) ? {8'h00, ~b, b, 8'h00}
            : {8'h00, b, ~b, 8'h00}, 16'h0200, 8'h5A);
        expect_pc_fl(e, 8'h5A);
        acc(1'b0, ADDR_STAT, 32'h0);
        check("skip_taken", {31'h0, rv[STAT_TAKEN_BIT]}, {31'h0, tk});
      end
    end
    $display("test skip done");
  endtask

  task automatic t_branch();
    logic [7:0] fs [4] = '{8'h00, 8'hFF, 8'h0A, 8'h05};
    logic [6:0] k;
    logic [15:0] e;
    for (int op = 7; op < 16; op++) begin
      for (int i = 0; i < 4; i++) begin
        k = op[0] ? 7'h7E : 7'h05;
        e = 16'h0100 + 16'h0001;
        if (cond(op[3:0], 3'h3, fs[i])) begin
          e = e + {{9{k[6]}}, k};
        end
        run(op[3:0], 3'h3, 1'b0, {1'b0, k, 24'h000000}, 16'h0100, fs[i]);
        expect_pc_fl(e, fs[i]);
      end
    end
    $display("test branch done");
  endtask

  task automatic t_busy();
    acc(1'b1, ADDR_PC, 32'h0000_0300);
    acc(1'b1, ADDR_OPND, 32'h0000_0100);
    xfer(1'b1, ADDR_OPER, 32'h0000_0084);
    check("oper_ok", {31'h0, er}, 32'h0000_0000);
    xfer(1'b1, ADDR_PC, 32'h0000_0777);
    check("busy_refused", {31'h0, er}, 32'h0000_0001);
    psel <= 1'b0;
    @(posedge pclk);
    wait_idle();
    acc(1'b0, ADDR_PC, 32'h0);
    check("busy_pc", rv, 32'h0000_0303);
    $display("test busy done");
  endtask

  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_compare();
    t_skip();
    t_branch();
    t_busy();
    stop_test();
  end
endmodule
`default_nettype wire
